// ==== rtl/epdu_pkg.sv ====
package epdu_pkg;

   // command codes, data/command select low
   localparam logic [7:0] CMD_MASTER_GO = 8'h20;
   localparam logic [7:0] CMD_SEQ_OPT   = 8'h22;
   localparam logic [7:0] CMD_WR_MONO   = 8'h24;
   localparam logic [7:0] CMD_WR_RED    = 8'h26;
   localparam logic [7:0] CMD_RD_RAM    = 8'h27;

   // update-sequence options handled here
   localparam logic [7:0] OPT_DISPLAY   = 8'hCF;
   localparam logic [7:0] OPT_LUT       = 8'h99;
   localparam logic [7:0] OPT_TS_LUT    = 8'hB9;
   localparam logic [7:0] OPT_RESET     = 8'hFF;

   localparam logic [7:0] DUMMY_BYTE    = 8'h00;

   // frame geometry: 128 x 296 pixels, one bit each
   localparam int PLANE_BYTES   = 4736;
   localparam int ADDR_W        = 13;
   localparam int TS_W          = 12;

   // length of each sequence stage in cycles
   localparam int STAGE_CYCLES_DEF = 16;

   typedef enum logic [2:0] {
      SEQ_IDLE    = 3'b000,
      SEQ_CLK_ON  = 3'b001,
      SEQ_ANA_ON  = 3'b011,
      SEQ_DISPLAY = 3'b010,
      SEQ_ANA_OFF = 3'b110,
      SEQ_OSC_OFF = 3'b111,
      SEQ_TS_LOAD = 3'b101,
      SEQ_LUT     = 3'b100
   } epdu_seq_e;

   typedef enum logic [2:0] {
      MODE_NONE    = 3'b000,
      MODE_OPT     = 3'b001,
      MODE_WR_MONO = 3'b011,
      MODE_WR_RED  = 3'b010,
      MODE_RD      = 3'b110
   } epdu_mode_e;

endpackage : epdu_pkg

// ==== rtl/epdu_core.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RQ1 - select low is command, high is data
// RQ2 - option byte picks stages, resets to FFh
// RQ3 - command 20h runs sequence, busy high
// RQ4 - CF: clock, analog, display, analog off, stop
// RQ5 - 99: clock, load LUT, stop oscillator
// RQ6 - B9: clock, load temperature, LUT, stop
// RQ7 - 24h streams data into mono plane
// RQ8 - mono plane: one white, zero black
// RQ9 - 26h streams data into red plane
// RQ10 - red plane: one red, zero not red
// RQ11 - 27h reads frame RAM, pointer advancing
// RQ12 - read plane picked by read-source setting
// RQ13 - first read byte is dummy
// RQ14 - pointer follows entry direction and window; code wraps win_end to win_start in both directions
module epdu_core #(
   parameter int          DEPTH        = epdu_pkg::PLANE_BYTES,
   parameter int          AW           = epdu_pkg::ADDR_W,
   parameter int          TSW          = epdu_pkg::TS_W,
   parameter logic [7:0]  STAGE_CYCLES = 8'(epdu_pkg::STAGE_CYCLES_DEF)
) (
   input  wire logic            mclk,
   input  wire logic            rstn,
   input  wire logic            byte_valid,
   input  wire logic            byte_dc,
   input  wire logic [7:0]      byte_data,
   input  wire logic            rd_req,
   output logic      [7:0]      rd_data,
   output logic                 rd_valid,
   input  wire logic            rd_src_red,
   input  wire logic            addr_dec,
   input  wire logic            ptr_load,
   input  wire logic [AW-1:0]   ptr_init,
   input  wire logic [AW-1:0]   win_start,
   input  wire logic [AW-1:0]   win_end,
   input  wire logic [AW-1:0]   scan_addr,
   output logic      [7:0]      scan_mono,
   output logic      [7:0]      scan_red,
   input  wire logic [TSW-1:0]  temperature_sensor_value,
   output logic      [TSW-1:0]  ts_latched,
   output logic      [7:0]      seq_option,
   output logic                 busy,
   output logic                 clk_en,
   output logic                 analog_en,
   output logic                 panel_drive,
   output logic                 lut_load,
   output logic                 ts_load,
   output logic                 osc_en
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic is_cmd(input logic       valid,
                                   input logic       dc,
                                   input logic [7:0] data,
                                   input logic [7:0] code);
      is_cmd = valid && !dc && (data == code);
   endfunction : is_cmd

   epdu_pkg::epdu_seq_e  seq_q;
   epdu_pkg::epdu_seq_e  seq_d;
   epdu_pkg::epdu_mode_e mode_q;
   epdu_pkg::epdu_mode_e mode_d;
   logic [7:0]           opt_q;
   logic [7:0]           cnt_q;
   logic [AW-1:0]        ptr_q;
   logic [AW-1:0]        ptr_step;
   logic                 dummy_q;
   logic [7:0]           rd_data_q;
   logic                 rd_valid_q;
   logic [TSW-1:0]       ts_q;
   logic [7:0]           scan_mono_q;
   logic [7:0]           scan_red_q;
   logic [7:0]           mono_mem [DEPTH];
   logic [7:0]           red_mem  [DEPTH];

   // bytes arriving during an update are dropped
   wire take      = byte_valid && !busy;
   wire take_cmd  = take && !byte_dc; // RQ1
   wire take_data = take && byte_dc; // RQ1
   wire go        = is_cmd(take, byte_dc, byte_data,
                           epdu_pkg::CMD_MASTER_GO); // RQ3
   wire opt_ok    = (opt_q == epdu_pkg::OPT_DISPLAY) ||
                    (opt_q == epdu_pkg::OPT_LUT) ||
                    (opt_q == epdu_pkg::OPT_TS_LUT);
   wire stage_end = (cnt_q == STAGE_CYCLES - 8'd1);
   wire wr_mono   = take_data && (mode_q == epdu_pkg::MODE_WR_MONO);
   wire wr_red    = take_data && (mode_q == epdu_pkg::MODE_WR_RED);
   wire rd_mode   = (mode_q == epdu_pkg::MODE_RD);
   wire rd_fetch  = rd_req && rd_mode && !dummy_q;
   wire advance   = wr_mono || wr_red || rd_fetch;

   ////////////////////////////////////////////////////////////////////////
   // command decoder

   always_comb begin
      mode_d = mode_q;
      if (take_cmd) begin
         case (byte_data)
            epdu_pkg::CMD_SEQ_OPT: mode_d = epdu_pkg::MODE_OPT;
            epdu_pkg::CMD_WR_MONO: mode_d = epdu_pkg::MODE_WR_MONO; // RQ7
            epdu_pkg::CMD_WR_RED:  mode_d = epdu_pkg::MODE_WR_RED; // RQ9
            epdu_pkg::CMD_RD_RAM:  mode_d = epdu_pkg::MODE_RD; // RQ11
            default:               mode_d = epdu_pkg::MODE_NONE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= epdu_pkg::MODE_NONE;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         opt_q <= epdu_pkg::OPT_RESET; // RQ2
      end else if (take_data && mode_q == epdu_pkg::MODE_OPT) begin
         opt_q <= byte_data; // RQ2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // update sequencer

   always_comb begin
      seq_d = seq_q;
      case (seq_q)
         epdu_pkg::SEQ_IDLE: begin
            if (go && opt_ok) begin
               seq_d = epdu_pkg::SEQ_CLK_ON; // RQ3
            end
         end
         epdu_pkg::SEQ_CLK_ON: begin
            if (stage_end) begin
               case (opt_q)
                  epdu_pkg::OPT_DISPLAY: seq_d = epdu_pkg::SEQ_ANA_ON; // RQ4
                  epdu_pkg::OPT_TS_LUT:  seq_d = epdu_pkg::SEQ_TS_LOAD; // RQ6
                  default:               seq_d = epdu_pkg::SEQ_LUT; // RQ5
               endcase
            end
         end
         epdu_pkg::SEQ_ANA_ON: begin
            if (stage_end) begin
               seq_d = epdu_pkg::SEQ_DISPLAY; // RQ4
            end
         end
         epdu_pkg::SEQ_DISPLAY: begin
            if (stage_end) begin
               seq_d = epdu_pkg::SEQ_ANA_OFF; // RQ4
            end
         end
         epdu_pkg::SEQ_ANA_OFF: begin
            if (stage_end) begin
               seq_d = epdu_pkg::SEQ_OSC_OFF; // RQ4
            end
         end
         epdu_pkg::SEQ_TS_LOAD: begin
            if (stage_end) begin
               seq_d = epdu_pkg::SEQ_LUT; // RQ6
            end
         end
         epdu_pkg::SEQ_LUT: begin
            if (stage_end) begin
               seq_d = epdu_pkg::SEQ_OSC_OFF; // RQ5 RQ6
            end
         end
         epdu_pkg::SEQ_OSC_OFF: begin
            if (stage_end) begin
               seq_d = epdu_pkg::SEQ_IDLE;
            end
         end
         default: seq_d = epdu_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         seq_q <= epdu_pkg::SEQ_IDLE;
         cnt_q <= 8'h00;
      end else begin
         seq_q <= seq_d;
         cnt_q <= (seq_d != seq_q || stage_end) ? 8'h00 : cnt_q + 8'd1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ts_q <= '0;
      end else if (seq_q == epdu_pkg::SEQ_TS_LOAD && stage_end) begin
         ts_q <= temperature_sensor_value; // RQ6
      end
   end

   assign busy        = (seq_q != epdu_pkg::SEQ_IDLE); // RQ3
   assign clk_en      = busy;
   assign analog_en   = (seq_q == epdu_pkg::SEQ_ANA_ON) ||
                        (seq_q == epdu_pkg::SEQ_DISPLAY);
   assign panel_drive = (seq_q == epdu_pkg::SEQ_DISPLAY);
   assign lut_load    = (seq_q == epdu_pkg::SEQ_LUT);
   assign ts_load     = (seq_q == epdu_pkg::SEQ_TS_LOAD);
   assign osc_en      = busy && (seq_q != epdu_pkg::SEQ_OSC_OFF);
   assign ts_latched  = ts_q;
   assign seq_option  = opt_q;

   ////////////////////////////////////////////////////////////////////////
   // address pointer and frame planes

   assign ptr_step = addr_dec ? ptr_q - AW'(1) : ptr_q + AW'(1);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ptr_q <= '0;
      end else if (ptr_load) begin
         ptr_q <= ptr_init;
      end else if (advance) begin
         ptr_q <= (ptr_q == win_end) ? win_start : ptr_step; // RQ14
      end
   end

   // planes hold pixels as sent: mono 1 white, red 1 red
   always_ff @(posedge mclk) begin
      if (wr_mono) begin
         mono_mem[ptr_q] <= byte_data; // RQ7 RQ8
      end
      if (wr_red) begin
         red_mem[ptr_q] <= byte_data; // RQ9 RQ10
      end
   end

   always_ff @(posedge mclk) begin
      scan_mono_q <= mono_mem[scan_addr];
      scan_red_q  <= red_mem[scan_addr];
   end

   assign scan_mono = scan_mono_q;
   assign scan_red  = scan_red_q;

   ////////////////////////////////////////////////////////////////////////
   // read stream

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dummy_q <= 1'b0;
      end else if (is_cmd(take, byte_dc, byte_data,
                          epdu_pkg::CMD_RD_RAM)) begin
         dummy_q <= 1'b1; // RQ13
      end else if (rd_req) begin
         dummy_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_req;
         if (rd_fetch) begin
            rd_data_q <= rd_src_red ? red_mem[ptr_q] : mono_mem[ptr_q]; // RQ12
         end else if (rd_req) begin
            rd_data_q <= epdu_pkg::DUMMY_BYTE; // RQ13
         end
      end
   end

   assign rd_data  = rd_data_q;
   assign rd_valid = rd_valid_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_stage_done(epdu_pkg::epdu_seq_e st);
      seq_q == st && stage_end;
   endsequence

   a_go_sets_busy: assert property (@(posedge mclk) disable iff (!rstn) // RQ3
      (go && opt_ok && !busy) |=> busy [*8])
      else $error("busy not held after master activation");

   a_opt_por: assert property (@(posedge mclk) disable iff (!rstn) // RQ2
      $rose(busy) && $past(opt_q) == 8'hFF |-> 1'b0)
      else $error("reset option value started a sequence");

   a_cf_order: assert property (@(posedge mclk) disable iff (!rstn) // RQ4
      s_stage_done(epdu_pkg::SEQ_CLK_ON) ##0 (opt_q == 8'hCF)
      |=> analog_en && !panel_drive ##[1:300] panel_drive)
      else $error("display option out of order");

   a_lut_no_drive: assert property (@(posedge mclk) disable iff (!rstn) // RQ5
      busy && opt_q == 8'h99 |-> !panel_drive && !analog_en)
      else $error("lut option drove the panel");

   a_ts_then_lut: assert property (@(posedge mclk) disable iff (!rstn) // RQ6
      s_stage_done(epdu_pkg::SEQ_TS_LOAD) |=> lut_load && !ts_load)
      else $error("lut did not follow temperature load");

   a_osc_last: assert property (@(posedge mclk) disable iff (!rstn) // RQ4
      s_stage_done(epdu_pkg::SEQ_OSC_OFF) |=> !busy && !clk_en)
      else $error("sequence did not end after oscillator stop");

   a_wr_advance: assert property (@(posedge mclk) disable iff (!rstn) // RQ7
      (wr_mono || wr_red) && !ptr_load && ptr_q != win_end
      |=> ptr_q == $past(ptr_step))
      else $error("pointer did not advance after write");

   a_stream_stop: assert property (@(posedge mclk) disable iff (!rstn) // RQ9
      take_cmd && byte_data != 8'h24 && byte_data != 8'h26
      |=> mode_q != epdu_pkg::MODE_WR_MONO && mode_q != epdu_pkg::MODE_WR_RED)
      else $error("write stream survived another command");

   a_dummy_first: assert property (@(posedge mclk) disable iff (!rstn) // RQ13
      rd_req && rd_mode && dummy_q
      |=> rd_valid && rd_data == 8'h00 && !dummy_q)
      else $error("first read byte not dummy");

   a_rd_advance: assert property (@(posedge mclk) disable iff (!rstn) // RQ11
      rd_fetch && !ptr_load && ptr_q != win_end |=> ptr_q == $past(ptr_step))
      else $error("pointer did not advance after read");

endmodule : epdu_core

`default_nettype wire

// ==== verification/epdu_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module epdu_host_model (
   input  wire logic       mclk,
   input  wire logic       busy,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output logic            byte_valid,
   output logic            byte_dc,
   output logic [7:0]      byte_data,
   output logic            rd_req
);
   initial begin
      byte_valid = 1'b0;
      byte_dc    = 1'b0;
      byte_data  = 8'h00;
      rd_req     = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic send(input logic dc, input logic [7:0] b, output logic ok);
      int n;
      n = 0;
      // hold off while an update runs
      while (busy === 1'b1 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      ok = (n < 1000);
      @(negedge mclk);
      byte_valid = 1'b1;
      byte_dc    = dc;
      byte_data  = b;
      @(negedge mclk);
      byte_valid = 1'b0;
      // released lines do not keep the last byte
      byte_data  = ~b;
   endtask : send
   ////////////////////////////////////////////////////////////////
   task automatic read(output logic [7:0] b, output logic v);
      @(negedge mclk);
      rd_req = 1'b1;
      @(negedge mclk);
      rd_req = 1'b0;
      // rd_valid stands only in the cycle after the request edge
      v = rd_valid;
      b = rd_data;
   endtask : read
endmodule : epdu_host_model
`default_nettype wire

// ==== verification/epd_update_and_ram_access_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module epd_update_and_ram_access_tb;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        byte_valid, byte_dc, rd_req, rd_valid;
   logic [7:0]  byte_data, rd_data, scan_mono, scan_red, seq_option;
   logic        rd_src_red = 1'b0;
   logic        addr_dec = 1'b0;
   logic        ptr_load = 1'b0;
   logic [12:0] ptr_init = 13'h0000;
   logic [12:0] scan_addr = 13'h0000;
   logic [11:0] ts_val = 12'h0_5A3;
   logic [11:0] ts_latched;
   logic        busy, clk_en, analog_en, panel_drive, lut_load, ts_load;
   logic        osc_en;
   int          fails = 0;
   int          check_count = 0;

   always #2.5 mclk = ~mclk;

   epdu_host_model host (.mclk(mclk), .busy(busy), .rd_valid(rd_valid),
      .rd_data(rd_data), .byte_valid(byte_valid), .byte_dc(byte_dc),
      .byte_data(byte_data), .rd_req(rd_req));

   epdu_core #(.STAGE_CYCLES(8'h04)) dut (.mclk(mclk), .rstn(rstn),
      .byte_valid(byte_valid), .byte_dc(byte_dc), .byte_data(byte_data),
      .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_src_red(rd_src_red), .addr_dec(addr_dec), .ptr_load(ptr_load),
      .ptr_init(ptr_init), .win_start(13'h0000), .win_end(13'h127F),
      .scan_addr(scan_addr), .scan_mono(scan_mono), .scan_red(scan_red),
      .temperature_sensor_value(ts_val), .ts_latched(ts_latched),
      .seq_option(seq_option), .busy(busy), .clk_en(clk_en),
      .analog_en(analog_en), .panel_drive(panel_drive),
      .lut_load(lut_load), .ts_load(ts_load), .osc_en(osc_en));
   ////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic put(input logic dc, input logic [7:0] b);
      logic ok;
      host.send(dc, b, ok);
      if (!ok) begin
         fails++;
         close_out();
      end
   endtask : put

   task automatic load_ptr(input logic [12:0] p);
      @(negedge mclk);
      ptr_init = p;
      ptr_load = 1'b1;
      @(negedge mclk);
      ptr_load = 1'b0;
   endtask : load_ptr

   task automatic peek(input logic        red,
                       input logic [12:0] a,
                       input logic [7:0]  e);
      @(negedge mclk);
      scan_addr = a;
      @(negedge mclk);
      chk(16'(red ? scan_red : scan_mono), 16'(e));
   endtask : peek

   task automatic rd_chk(input logic [7:0] e);
      logic [7:0] b;
      logic       v;
      host.read(b, v);
      chk(16'(v), 16'h0001);
      chk(16'(b), 16'(e));
   endtask : rd_chk
   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(16'(seq_option), 16'h00FF);
      put(1'b0, 8'h20);
      repeat (4) @(negedge mclk);
      chk(16'(busy), 16'h0000);
   endtask : t_reset

   task automatic t_write;
      load_ptr(13'h0000);
      put(1'b0, 8'h24);
      put(1'b1, 8'hAA);
      put(1'b1, 8'h55);
      put(1'b0, 8'h26);
      load_ptr(13'h0000);
      put(1'b1, 8'h0F);
      put(1'b1, 8'hF0);
      addr_dec = 1'b1;
      load_ptr(13'h0009);
      put(1'b0, 8'h24);
      put(1'b1, 8'h11);
      put(1'b1, 8'h22);
      addr_dec = 1'b0;
      peek(1'b0, 13'h0000, 8'hAA);
      peek(1'b0, 13'h0001, 8'h55);
      peek(1'b1, 13'h0000, 8'h0F);
      peek(1'b1, 13'h0001, 8'hF0);
      peek(1'b0, 13'h0009, 8'h11);
      peek(1'b0, 13'h0008, 8'h22);
   endtask : t_write

   task automatic t_read;
      load_ptr(13'h0000);
      put(1'b0, 8'h27);
      rd_chk(8'h00);
      rd_chk(8'hAA);
      rd_chk(8'h55);
      rd_src_red = 1'b1;
      load_ptr(13'h0000);
      put(1'b0, 8'h27);
      rd_chk(8'h00);
      rd_chk(8'h0F);
      rd_src_red = 1'b0;
      put(1'b0, 8'h24);
      rd_chk(8'h00);
   endtask : t_read

   task automatic t_wrap;
      load_ptr(13'h127F);
      put(1'b0, 8'h24);
      put(1'b1, 8'h3C);
      put(1'b1, 8'hC3);
      peek(1'b0, 13'h127F, 8'h3C);
      peek(1'b0, 13'h0000, 8'hC3);
   endtask : t_wrap

   task automatic t_update;
      logic [7:0] opt [3] = '{8'hCF, 8'h99, 8'hB9};
      logic [4:0] msk [3] = '{5'b1_1100, 5'b1_0010, 5'b1_0011};
      int         stg [3] = '{5, 3, 4};
      logic [4:0] seen;
      int         n;
      int         off;
      for (int i = 0; i < 3; i++) begin
         put(1'b0, 8'h22);
         put(1'b1, opt[i]);
         chk(16'(seq_option), 16'(opt[i]));
         put(1'b0, 8'h20);
         n = 0;
         off = 0;
         seen = '0;
         while (busy !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
         end
         if (n == 4) begin
            fails++;
            close_out();
         end
         n = 0;
         while (busy === 1'b1 && n < 100) begin
            seen |= {clk_en, analog_en, panel_drive, lut_load, ts_load};
            if (osc_en !== 1'b1) begin
               off++;
            end
            @(negedge mclk);
            n++;
         end
         if (n == 100) begin
            fails++;
            close_out();
         end
         chk(16'(n), 16'(stg[i] * 4));
         chk(16'(seen), 16'(msk[i]));
         chk(16'(osc_en), 16'h0000);
         chk(16'(off), 16'h0004);
      end
      chk(16'(ts_latched), 16'(ts_val));
   endtask : t_update
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
      t_reset();
      t_write();
      t_read();
      t_wrap();
      t_update();
      close_out();
   end
endmodule : epd_update_and_ram_access_tb
`default_nettype wire
